// file: logic/uhc_defs.svh
// What this block does
// - The enhanced interface version reads 0100h when identifiers came from the serial EEPROM or the serial clock is held low, and 0095h otherwise.
// - The low eight bits of the legacy version register are read-only and hold the implemented interface version as two BCD digits.
// - The legacy version field always returns 10h.
// - Bits 31 to 8 of the legacy version register are read-only and read as zero.
// - Only host driver software changes the control fields, except the functional state and remote-wakeup-connected bits, which hardware may also update.
// - The control register holds wakeup enable at 10, wakeup connected at 9, interrupt routing at 8, functional state at 7:6, list enables at 5:2 and service ratio at 1:0, all resetting to zero.
// - A software reset enters the suspend state; a hardware reset enters the reset state, resets the root hub and drives reset signaling downstream.
`ifndef UHC_DEFS_SVH
`define UHC_DEFS_SVH

`define UHC_ADDR_W            8
`define UHC_OFS_VERSION       8'h00
`define UHC_OFS_CONTROL       8'h04
`define UHC_OFS_PORT1         8'h64
`define UHC_OFS_PORT2         8'h68
`define UHC_OFS_TUNING        8'h6c

`define UHC_LEGACY_REV        8'h10
`define UHC_CAP_LENGTH        8'h20
`define UHC_EVER_NEW          16'h0100
`define UHC_EVER_OLD          16'h0095

`define UHC_CTL_WAKE_EN       10
`define UHC_CTL_WAKE_CONN     9
`define UHC_CTL_INT_ROUTE     8
`define UHC_CTL_FS_HI         7
`define UHC_CTL_FS_LO         6
`define UHC_CTL_BULK_EN       5
`define UHC_CTL_CTRL_EN       4
`define UHC_CTL_ISO_EN        3
`define UHC_CTL_PER_EN        2
`define UHC_CTL_RATIO_HI      1
`define UHC_CTL_RATIO_LO      0

`define UHC_PORT_RESET        32'h0000_0000
`define UHC_TUNING_RESET      32'h0000_0000

`endif

// file: logic/uhc_pkg.sv
package uhc_pkg;

  typedef enum logic [1:0] {
    UHC_FS_BUS_RESET   = 2'h0,
    UHC_FS_RESUME      = 2'h1,
    UHC_FS_OPERATIONAL = 2'h2,
    UHC_FS_SUSPENDED   = 2'h3
  } uhc_fs_t;

  typedef struct packed {
    logic       remote_wakeup_enable;
    logic       remote_wakeup_connected;
    logic       interrupt_routing;
    uhc_fs_t    functional_state;
    logic       bulk_list_enable;
    logic       control_list_enable;
    logic       isochronous_enable;
    logic       periodic_list_enable;
    logic [1:0] control_bulk_service_ratio;
  } uhc_ctrl_t;

  typedef struct packed {
    uhc_ctrl_t   ctrl;
    logic [31:0] rdata;
    logic        rvalid;
  } uhc_state_t;

endpackage : uhc_pkg

// file: logic/uhc_rw_reg.sv
`timescale 1ns/10ps
`include "uhc_defs.svh"

module uhc_rw_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic        clk,    // bus clock
  input  wire logic        rst_n,  // synchronous reset
  input  wire logic        wr_en,  // write strobe for this word
  input  wire logic [3:0]  be,     // byte enables
  input  wire logic [31:0] wdata,  // write data
  output logic      [31:0] value   // stored word
);

  logic [31:0] value_q;
  logic [31:0] value_d;

  always_comb begin
    value_d = value_q;
    for (int i = 0; i < 4; i++) begin
      if (wr_en && be[i]) begin
        value_d[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule : uhc_rw_reg

// file: logic/uhc_regs.sv
`timescale 1ns/10ps
`include "uhc_defs.svh"

module uhc_regs
  import uhc_pkg::*;
(
  input  wire logic                  clk,              // bus clock
  input  wire logic                  rst_n,            // hardware reset, sync
  input  wire logic                  func_sel,         // 0 legacy, 1 enhanced
  input  wire logic [`UHC_ADDR_W-1:0] addr,            // byte offset
  input  wire logic                  wr_en,            // write strobe
  input  wire logic [3:0]            be,               // byte enables
  input  wire logic [31:0]           wdata,            // write data
  input  wire logic                  rd_en,            // read strobe
  output logic      [31:0]           rdata,            // read data
  output logic                       rvalid,           // read data valid
  input  wire logic                  soft_reset,       // software reset pulse
  input  wire logic                  resume_detect,    // downstream resume pulse
  input  wire logic                  wakeup_connect,   // firmware wakeup capable pulse
  input  wire logic                  eeprom_loaded,    // ids came from EEPROM
  input  wire logic                  scl_low,          // serial clock held low
  output logic      [1:0]            functional_state, // current state
  output logic                       root_hub_reset,   // root hub held in reset
  output logic                       port_reset_drive, // reset signaling downstream
  output logic      [31:0]           port1_status_control, // port 1 word
  output logic      [31:0]           port2_status_control, // port 2 word
  output logic      [31:0]           system_tuning     // tuning word
);

  // ****************************************
  // state
  // ****************************************
  uhc_state_t s_q;
  uhc_state_t s_d;
  logic       hw_rst_q;

  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic [15:0] ever;
  logic        enh_wr;
  logic        legacy_ctl_wr;

  // ****************************************
  // address decode
  // ****************************************
  logic        hit_control;
  logic        hit_port1;
  logic        hit_port2;
  logic        hit_tuning;
  logic        wr_port1;
  logic        wr_port2;
  logic        wr_tuning;
  logic        ctl_lo_wr;
  logic        ctl_hi_wr;
  logic        resume_ok;

  assign hit_control   = (addr == `UHC_OFS_CONTROL);
  assign hit_port1     = (addr == `UHC_OFS_PORT1);
  assign hit_port2     = (addr == `UHC_OFS_PORT2);
  assign hit_tuning    = (addr == `UHC_OFS_TUNING);

  // the two functions share offsets, so func_sel splits every strobe
  assign legacy_ctl_wr = wr_en && !func_sel && hit_control;
  assign enh_wr        = wr_en && func_sel;
  assign wr_port1      = enh_wr && hit_port1;
  assign wr_port2      = enh_wr && hit_port2;
  assign wr_tuning     = enh_wr && hit_tuning;

  // byte lane 0 carries bits 7:0, lane 1 bits 10:8; lanes 2 and 3 hold nothing
  assign ctl_lo_wr     = legacy_ctl_wr && be[0];
  assign ctl_hi_wr     = legacy_ctl_wr && be[1];

  // ****************************************
  // hardware event qualifiers
  // ****************************************
  // resume only moves the state out of suspend
  assign resume_ok = resume_detect && (s_q.ctrl.functional_state == UHC_FS_SUSPENDED);

  // ****************************************
  // interface version select
  // ****************************************
  // the straps are levels, so the version word follows them directly
  assign ever = (eeprom_loaded || scl_low) ? `UHC_EVER_NEW : `UHC_EVER_OLD;

  // ****************************************
  // enhanced port and tuning words
  // ****************************************
  uhc_rw_reg #(.RESET_VAL(`UHC_PORT_RESET)) u_port1 (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_en (wr_port1),
    .be    (be),
    .wdata (wdata),
    .value (port1_status_control)
  );

  uhc_rw_reg #(.RESET_VAL(`UHC_PORT_RESET)) u_port2 (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_en (wr_port2),
    .be    (be),
    .wdata (wdata),
    .value (port2_status_control)
  );

  uhc_rw_reg #(.RESET_VAL(`UHC_TUNING_RESET)) u_tuning (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_en (wr_tuning),
    .be    (be),
    .wdata (wdata),
    .value (system_tuning)
  );

  // ****************************************
  // control word layout
  // ****************************************
  always_comb begin
    ctrl_word                                        = 32'h0000_0000;
    ctrl_word[`UHC_CTL_WAKE_EN]                      = s_q.ctrl.remote_wakeup_enable;
    ctrl_word[`UHC_CTL_WAKE_CONN]                    = s_q.ctrl.remote_wakeup_connected;
    ctrl_word[`UHC_CTL_INT_ROUTE]                    = s_q.ctrl.interrupt_routing;
    ctrl_word[`UHC_CTL_FS_HI:`UHC_CTL_FS_LO]         = s_q.ctrl.functional_state;
    ctrl_word[`UHC_CTL_BULK_EN]                      = s_q.ctrl.bulk_list_enable;
    ctrl_word[`UHC_CTL_CTRL_EN]                      = s_q.ctrl.control_list_enable;
    ctrl_word[`UHC_CTL_ISO_EN]                       = s_q.ctrl.isochronous_enable;
    ctrl_word[`UHC_CTL_PER_EN]                       = s_q.ctrl.periodic_list_enable;
    ctrl_word[`UHC_CTL_RATIO_HI:`UHC_CTL_RATIO_LO]   = s_q.ctrl.control_bulk_service_ratio;
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!func_sel) begin
      unique case (addr)
        `UHC_OFS_VERSION: rd_word = {24'h00_0000, `UHC_LEGACY_REV};
        `UHC_OFS_CONTROL: rd_word = ctrl_word;
        default:          rd_word = 32'h0000_0000;
      endcase
    end else begin
      unique case (addr)
        `UHC_OFS_VERSION: rd_word = {ever, 8'h00, `UHC_CAP_LENGTH};
        `UHC_OFS_PORT1:   rd_word = port1_status_control;
        `UHC_OFS_PORT2:   rd_word = port2_status_control;
        `UHC_OFS_TUNING:  rd_word = system_tuning;
        default:          rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = rd_en;
    s_d.rdata  = rd_en ? rd_word : s_q.rdata;
    // version word has no storage, so writes to it fall through
    // bits 31:11 are not stored
    // software side: the driver writes these fields; the hardware side below also updates wakeup connected and functional state
    if (ctl_hi_wr) begin
      s_d.ctrl.remote_wakeup_enable    = wdata[`UHC_CTL_WAKE_EN];
      s_d.ctrl.remote_wakeup_connected = wdata[`UHC_CTL_WAKE_CONN];
      s_d.ctrl.interrupt_routing       = wdata[`UHC_CTL_INT_ROUTE];
    end
    if (ctl_lo_wr) begin
      s_d.ctrl.functional_state = uhc_fs_t'(wdata[`UHC_CTL_FS_HI:`UHC_CTL_FS_LO]);
      s_d.ctrl.bulk_list_enable           = wdata[`UHC_CTL_BULK_EN];
      s_d.ctrl.control_list_enable        = wdata[`UHC_CTL_CTRL_EN];
      s_d.ctrl.isochronous_enable         = wdata[`UHC_CTL_ISO_EN];
      s_d.ctrl.periodic_list_enable       = wdata[`UHC_CTL_PER_EN];
      s_d.ctrl.control_bulk_service_ratio =
        wdata[`UHC_CTL_RATIO_HI:`UHC_CTL_RATIO_LO];
    end
    // hardware side: updates win over a software write in the same cycle
    if (wakeup_connect) begin
      s_d.ctrl.remote_wakeup_connected = 1'b1;
    end
    if (resume_ok) begin
      s_d.ctrl.functional_state = UHC_FS_RESUME;
    end
    if (soft_reset) begin
      // software reset keeps routing and wakeup connected
      s_d.ctrl.remote_wakeup_enable       = 1'b0;
      s_d.ctrl.functional_state           = UHC_FS_SUSPENDED;
      s_d.ctrl.bulk_list_enable           = 1'b0;
      s_d.ctrl.control_list_enable        = 1'b0;
      s_d.ctrl.isochronous_enable         = 1'b0;
      s_d.ctrl.periodic_list_enable       = 1'b0;
      s_d.ctrl.control_bulk_service_ratio = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q      <= '0;
      hw_rst_q <= 1'b1;
    end else begin
      s_q      <= s_d;
      hw_rst_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata            = s_q.rdata;
  assign rvalid           = s_q.rvalid;
  assign functional_state = s_q.ctrl.functional_state;
  assign root_hub_reset   = hw_rst_q;
  assign port_reset_drive = (s_q.ctrl.functional_state == UHC_FS_BUS_RESET);

endmodule : uhc_regs

// file: test/uhc_regs_asserts.sv
`timescale 1ns/10ps
// ******************
// register checker
// ******************
module uhc_regs_asserts (
  input wire logic        clk,              // clock
  input wire logic        rst_n,            // reset
  input wire logic        func_sel,         // function
  input wire logic [7:0]  addr,             // offset
  input wire logic        wr_en,            // write
  input wire logic [3:0]  be,               // lanes
  input wire logic [31:0] wdata,            // wdata
  input wire logic        rd_en,            // read
  input wire logic [31:0] rdata,            // rdata
  input wire logic        soft_reset,       // sw reset
  input wire logic        resume_detect,    // resume
  input wire logic        eeprom_loaded,    // ids
  input wire logic        scl_low,          // clock low
  input wire logic [1:0]  functional_state, // state
  input wire logic        root_hub_reset,   // hub reset
  input wire logic        port_reset_drive  // drive
);
  wire logic [1:0] wr_fs = wdata[7:6];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_rev_value: assert property (rd_en && !func_sel && addr == 8'h00 |=> rdata == 32'h10)
    else $error("legacy version wrong");
  a_ever_value: assert property (rd_en && func_sel && addr == 8'h00 |=> rdata ==
    {($past(eeprom_loaded) || $past(scl_low)) ? 16'h0100 : 16'h0095, 16'h0020}) else $error("ever");
  a_ctl_write: assert property (wr_en && !func_sel && addr == 8'h04 && be[0] && !soft_reset &&
    !resume_detect |=> functional_state == $past(wr_fs)) else $error("state write lost");
  a_soft_susp: assert property (soft_reset |=> functional_state == 2'h3)
    else $error("soft reset state");
  a_hw_reset: assert property ($rose(rst_n) |-> functional_state == 2'h0 && root_hub_reset)
    else $error("hw reset state");
  a_drive_bus: assert property (port_reset_drive == (functional_state == 2'h0))
    else $error("reset drive");
  a_resume_go: assert property (resume_detect && !soft_reset && functional_state == 2'h3
    |=> functional_state == 2'h1) else $error("resume");
  a_fs_hold: assert property (!wr_en && !soft_reset && !resume_detect |=> $stable(functional_state))
    else $error("state moved");
endmodule : uhc_regs_asserts

// file: test/test_usb_host_ctrl_revision_control_regs.sv
`timescale 1ns/10ps
// ******
// bench
// ******
module test_usb_host_ctrl_revision_control_regs import uhc_pkg::*;;
  logic        clk, rst_n, func_sel, wr_en, rd_en, soft_reset, resume_detect, wakeup_connect;
  logic        eeprom_loaded, scl_low, rvalid, root_hub_reset, port_reset_drive;
  logic [1:0]  functional_state;
  logic [3:0]  be;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, exp, m_ctl, pw [3], m_w [3];
  logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h64, 8'h68, 8'h6c, 8'h70};
  int          failures = 0, n_checks = 0, i, k;
  integer      seed = 32'hdc3b;

  always #4 clk = ~clk;

  uhc_regs DUT (.clk, .rst_n, .func_sel, .addr, .wr_en, .be, .wdata, .rd_en, .rdata, .rvalid,
    .soft_reset, .resume_detect, .wakeup_connect, .eeprom_loaded, .scl_low, .functional_state,
    .root_hub_reset, .port_reset_drive, .port1_status_control(pw[0]),
    .port2_status_control(pw[1]), .system_tuning(pw[2]));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  function automatic logic [31:0] m_rd(input logic f, input logic [7:0] a);
    if (!f) return (a == 8'h00) ? 32'h10 : (a == 8'h04) ? m_ctl : 32'h0;
    if (a == 8'h00) return {(eeprom_loaded | scl_low) ? 16'h0100 : 16'h0095, 16'h0020};
    return (a inside {8'h64, 8'h68, 8'h6c}) ? m_w[(a - 8'h64) >> 2] : 32'h0;
  endfunction : m_rd

  function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] b);
    for (int j = 0; j < 4; j++) if (b[j]) o[8*j+:8] = d[8*j+:8];
    return o;
  endfunction : mrg

  // one access, then compare the model with every output except root_hub_reset, checking rdata only when the access reads
  task automatic op(input logic w, r, f, input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    int j;
    @(posedge clk);
    #1 {wr_en, rd_en, func_sel, addr, be, wdata} = {w, r, f, a, b, d};
    @(posedge clk);
    #1 {wr_en, rd_en} = 2'h0;
    exp = m_rd(f, a);
    j = (a - 8'h64) >> 2;
    if (w && !f && a == 8'h04) m_ctl = mrg(m_ctl, d, b) & 32'h7ff;
    if (w && f && a inside {8'h64, 8'h68, 8'h6c}) m_w[j] = mrg(m_w[j], d, b);
    if (r) chk(rdata, exp);
    chk(rvalid, r);
    chk(functional_state, m_ctl[7:6]);
    chk(port_reset_drive, m_ctl[7:6] == 2'h0);
    for (int n = 0; n < 3; n++) chk(pw[n], m_w[n]);
  endtask : op

  // 0 software reset, 1 resume, 2 wakeup connect
  task automatic ev(input int e);
    @(posedge clk);
    #1 {wakeup_connect, resume_detect, soft_reset} = 3'h1 << e;
    @(posedge clk);
    #1 {wakeup_connect, resume_detect, soft_reset} = 3'h0;
    if (e == 0) m_ctl = (m_ctl & 32'h300) | 32'hc0;
    if (e == 1 && m_ctl[7:6] == 2'h3) m_ctl[7:6] = 2'h1;
    if (e == 2) m_ctl[9] = 1'h1;
    op(1'h0, 1'h1, 1'h0, 8'h04, 4'h0, 32'h0);
  endtask : ev

  task automatic rst();
    rst_n = 1'h0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    {m_ctl, m_w[0], m_w[1], m_w[2]} = '0;
    chk(root_hub_reset, 32'h1);
    chk(functional_state, 32'h0);
  endtask : rst

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end

  initial begin
    {clk, func_sel, wr_en, rd_en, soft_reset, resume_detect, wakeup_connect} = 7'h0;
    {eeprom_loaded, scl_low, addr, be, wdata} = '0;
    rst();
    for (i = 0; i < 4; i++) begin
      {eeprom_loaded, scl_low} = i[1:0];
      op(1'h0, 1'h1, 1'h1, 8'h00, 4'h0, 32'h0);
    end
    chk(root_hub_reset, 32'h0);
    for (i = 0; i < 12; i++) op(1'h0, 1'h1, i[0], ofs[i >> 1], 4'h0, 32'h0);
    op(1'h1, 1'h1, 1'h0, 8'h00, 4'hf, 32'hffffffff);
    op(1'h0, 1'h1, 1'h0, 8'h00, 4'h0, 32'h0);
    op(1'h1, 1'h1, 1'h0, 8'h04, 4'hf, 32'h7ff);
    op(1'h1, 1'h1, 1'h0, 8'h04, 4'h2, 32'h100);
    ev(2);
    ev(0);
    ev(1);
    ev(1);
    for (i = 0; i < 300; i++) begin
      k = $random(seed);
      {eeprom_loaded, scl_low} = k[17:16];
      if (k[3:2] == 2'h0) ev(k[5:4] % 3);
      else op(k[6], k[7], k[8], ofs[k[11:9] % 6], k[15:12],
              $random(seed) & (k[8] ? '1 : 32'h7ff));
    end
    rst();
    op(1'h0, 1'h1, 1'h0, 8'h04, 4'h0, 32'h0);
    tally_and_finish();
  end
endmodule : test_usb_host_ctrl_revision_control_regs

bind uhc_regs uhc_regs_asserts u_chk (.clk, .rst_n, .func_sel, .addr, .wr_en, .be, .wdata, .rd_en,
  .rdata, .soft_reset, .resume_detect, .eeprom_loaded, .scl_low, .functional_state,
  .root_hub_reset, .port_reset_drive);
